// ===== src/iose_encoder.sv
// module: apb slave and registered state word of one i/o module slot
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none

module iose_encoder (
  input  wire logic        clk_sys,      // 125 MHz system clock
  input  wire logic        arst_n,       // asynchronous reset, active low
  input  wire logic        psel,         // apb select
  input  wire logic        penable,      // apb access phase
  input  wire logic        pwrite,       // apb direction, 1 = write
  input  wire logic [7:0]  paddr,        // apb byte address
  input  wire logic [31:0] pwdata,       // apb write data
  input  wire logic [3:0]  pstrb,        // apb byte strobes
  output logic      [31:0] prdata,       // apb read data, registered
  output logic             pready,       // apb ready
  output logic             pslverr,      // apb error for unmapped address
  input  wire logic        fastOffErr,   // collective fast shut-off error
  input  wire logic        supplyErr,    // output supply error
  input  wire logic        cfgInvalid,   // configuration not valid
  input  wire logic        extErr,       // external module error
  input  wire logic        intErr,       // internal module error
  input  wire logic        outDataErr,   // output data error
  input  wire logic        inDataErr,    // input data error
  input  wire logic [3:0]  pairErr,      // two-channel error, pairs 1-2 .. 7-8
  input  wire logic [7:0]  pulseErr,     // test pulse mismatch, inputs 1 .. 8
  input  wire logic [3:0]  stuckLowErr,  // stuck-at-low, outputs 1 .. 4
  input  wire logic [3:0]  stuckHighErr, // stuck-at-high, outputs 1 .. 4
  output logic      [31:0] stateWord,    // state word, byte 0 low, registered
  output logic      [2:0]  sendLen       // bytes to forward, registered
);

  iose_flag_if flg ();

  logic [2:0]  ctrl_q;
  logic [26:0] flags_q;
  logic [26:0] flags_d;
  logic [31:0] state_q;
  logic [2:0]  sendLen_q;
  logic [2:0]  sendLen_d;
  logic [31:0] prdata_q;
  logic [31:0] rdMux;
  logic        err_q;
  logic        hit;
  logic        setup;
  logic        wrAcc;
  logic        presentSafe;
  logic        presentDio;

  // ==========================================================================
  // apb phases: zero wait states, answer in the access phase
  assign setup  = psel & ~penable;
  assign pready = psel & penable;
  assign wrAcc  = psel & penable & pwrite;
  assign pslverr = psel & penable & err_q;

  // address decode
  always_comb
  begin
    hit   = 1'b1;
    rdMux = 32'h0000_0000;
    if (paddr == iose_pkg::ADDR_CTRL)
    begin
      rdMux[2:0] = ctrl_q;
    end
    else if (paddr == iose_pkg::ADDR_STATE)
    begin
      rdMux = state_q;
    end
    else if (paddr == iose_pkg::ADDR_FLAGS)
    begin
      rdMux[26:0] = flags_q;
    end
    else
    begin
      hit = 1'b0;
    end
  end

  // read data and decode error captured in the setup cycle
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prdata_q <= 32'h0000_0000;
      err_q    <= 1'b0;
    end
    else if (setup)
    begin
      prdata_q <= pwrite ? 32'h0000_0000 : rdMux;
      err_q    <= ~hit;
    end
  end

  assign prdata = prdata_q;

  // control register, low byte lane only
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_q <= iose_pkg::CTRL_RST;
    end
    else if (wrAcc && !err_q && pstrb[0] && paddr == iose_pkg::ADDR_CTRL)
    begin
      ctrl_q <= pwdata[2:0];
    end
  end

  // ==========================================================================
  // flag sampling from same-clock detection logic
  always_comb
  begin
    flags_d = iose_pkg::FLAGS_RST;
    flags_d[iose_pkg::ERR_FASTOFF] = fastOffErr;
    flags_d[iose_pkg::ERR_SUPPLY]  = supplyErr;
    flags_d[iose_pkg::ERR_CFG]     = cfgInvalid;
    flags_d[iose_pkg::ERR_EXT]     = extErr;
    flags_d[iose_pkg::ERR_INT]     = intErr;
    flags_d[iose_pkg::ERR_OUTD]    = outDataErr;
    flags_d[iose_pkg::ERR_IND]     = inDataErr;
    flags_d[iose_pkg::ERR_PAIR_LSB +: 4] = pairErr;
    flags_d[iose_pkg::ERR_PULS_LSB +: 8] = pulseErr;
    flags_d[iose_pkg::ERR_LOW_LSB +: 4]  = stuckLowErr;
    flags_d[iose_pkg::ERR_HIGH_LSB +: 4] = stuckHighErr;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flags_q <= iose_pkg::FLAGS_RST;
    end
    else
    begin
      flags_q <= flags_d;
    end
  end

  // ==========================================================================
  // byte assembly through the carrier interface
  assign flg.err     = flags_q;
  assign flg.kindDio = ctrl_q[iose_pkg::CTRL_KIND_BIT];
  assign flg.present = ctrl_q[iose_pkg::CTRL_PRES_BIT];

  iose_state_asm iose_state_asm_i (
    .flg (flg.asm)
  );

  // forwarded length: plain dio sends byte 0 unless told otherwise
  always_comb
  begin
    sendLen_d = iose_pkg::SEND_ALL;
    if (flg.present && flg.kindDio == iose_pkg::IOSE_PLAIN_DIO
        && !ctrl_q[iose_pkg::CTRL_FWDALL_BIT])
    begin
      sendLen_d = iose_pkg::SEND_ONE;
    end
  end

  // registered state word, empty slot after reset
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q   <= iose_pkg::STATE_RST;
      sendLen_q <= iose_pkg::SEND_ALL;
    end
    else
    begin
      state_q   <= flg.word;
      sendLen_q <= sendLen_d;
    end
  end

  assign stateWord = state_q;
  assign sendLen   = sendLen_q;

  // ==========================================================================
  // checks
  assign presentSafe = ctrl_q[iose_pkg::CTRL_PRES_BIT] & ~ctrl_q[iose_pkg::CTRL_KIND_BIT];
  assign presentDio  = ctrl_q[iose_pkg::CTRL_PRES_BIT] & ctrl_q[iose_pkg::CTRL_KIND_BIT];

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  AST_SAFE_INT_LOW: assert property (
    presentSafe && intErr ##1 presentSafe |=> !stateWord[1]
  ) else $error("internal error not shown as zero");

  AST_SAFE_FASTOFF: assert property (
    presentSafe && !fastOffErr ##1 presentSafe |=> stateWord[6]
  ) else $error("fast shut-off bit low without error");

  AST_SAFE_PAIRS: assert property (
    presentSafe |=> stateWord[11:8] == ~$past(flags_q[10:7])
  ) else $error("pair results misplaced in byte 1");

  AST_DIO_BYTE0: assert property (
    presentDio |=> stateWord[7:6] == 2'h3 && stateWord[0] && stateWord[3]
  ) else $error("dio byte 0 reserved or unused bit not one");

  AST_DIO_SENDLEN: assert property (
    presentDio && !ctrl_q[2] |=> sendLen == 3'h1
  ) else $error("dio forwards more than byte 0");

  AST_DIO_SUPPLY: assert property (
    presentDio && supplyErr ##1 presentDio |=> !stateWord[5] && stateWord[4] == !$past(cfgInvalid, 2)
  ) else $error("dio supply or config bit wrong");

  AST_DIO_TAIL: assert property (
    presentDio |=> stateWord[31:16] == 16'hFFFF && stateWord[13:8] == 6'h3F
  ) else $error("dio reserved bytes not all ones");

  AST_SAFE_STUCK: assert property (
    presentSafe && stuckLowErr[0] && !stuckHighErr[0] ##1 presentSafe
    |=> !stateWord[25] && stateWord[24]
  ) else $error("stuck-at pair of output 1 wrong");

  AST_EMPTY_SLOT: assert property (
    !ctrl_q[1] |=> stateWord == 32'hFFFF_FFFF && stateWord[7]
  ) else $error("empty slot not all ones");

  // ==========================================================================
  // field checks against the flags sampled one cycle earlier, then length checks and flag sampling checks against the inputs
  AST_SAFE_FASTOFF_ERR: assert property (
    presentSafe |=> stateWord[6] == !$past(flags_q[0])
  ) else $error("fast shut-off bit does not follow its flag");

  AST_SAFE_BYTE0: assert property (
    presentSafe |=> stateWord[5] == !$past(flags_q[1]) && stateWord[4] == !$past(flags_q[2])
  ) else $error("safe supply or config bit wrong");

  AST_SAFE_EXT: assert property (
    presentSafe |=> stateWord[2] == !$past(flags_q[3]) && stateWord[1] == !$past(flags_q[4])
  ) else $error("safe external or internal bit wrong");

  AST_SAFE_UNUSED: assert property (
    presentSafe |=> stateWord[3] && stateWord[0]
  ) else $error("safe unused bit not one");

  AST_SAFE_DATA: assert property (
    presentSafe |=> stateWord[15] == !$past(flags_q[5]) && stateWord[14] == !$past(flags_q[6])
  ) else $error("safe data state bits wrong");

  AST_SAFE_RESERVED: assert property (
    presentSafe |=> stateWord[7] && stateWord[13:12] == 2'h3
  ) else $error("safe reserved bit not one");

  AST_SAFE_PULSE: assert property (
    presentSafe |=> stateWord[23:16] == ~$past(flags_q[18:11])
  ) else $error("test pulse byte wrong");

  AST_SAFE_STUCK4: assert property (
    presentSafe |=> stateWord[31] == !$past(flags_q[22]) && stateWord[30] == !$past(flags_q[26])
  ) else $error("stuck-at pair of output 4 wrong");

  AST_SAFE_STUCK3: assert property (
    presentSafe |=> stateWord[29] == !$past(flags_q[21]) && stateWord[28] == !$past(flags_q[25])
  ) else $error("stuck-at pair of output 3 wrong");

  AST_DIO_DATA: assert property (
    presentDio |=> stateWord[15] == !$past(flags_q[5]) && stateWord[14] == !$past(flags_q[6])
  ) else $error("dio data state bits wrong");

  AST_DIO_EXT: assert property (
    presentDio |=> stateWord[2] == !$past(flags_q[3]) && stateWord[1] == !$past(flags_q[4])
  ) else $error("dio external or internal bit wrong");

  AST_DIO_CFG: assert property (
    presentDio |=> stateWord[5] == !$past(flags_q[1]) && stateWord[4] == !$past(flags_q[2])
  ) else $error("dio supply or config bit not inverted flag");

  AST_DIO_FULL_LEN: assert property (
    presentDio && ctrl_q[2] |=> sendLen == 3'h4
  ) else $error("dio forward all does not send four bytes");

  AST_EMPTY_LEN: assert property (
    !ctrl_q[1] |=> sendLen == 3'h4
  ) else $error("empty slot length not four");

  AST_FLAGS_INT: assert property (
    1'b1 |=> flags_q[4] == $past(intErr)
  ) else $error("internal error flag not sampled");

  AST_FLAGS_PULSE: assert property (
    1'b1 |=> flags_q[18:11] == $past(pulseErr)
  ) else $error("test pulse flags not sampled");

  COV_SAFE_ERR:  cover property (presentSafe ##1 presentSafe && stateWord != 32'hFFFF_FFFF);
  COV_DIO_ERR:   cover property (presentDio ##1 presentDio && stateWord[7:0] != 8'hFF);
  COV_CTRL_WR:   cover property (wrAcc && paddr == 8'h00);
  COV_UNMAPPED:  cover property (pslverr);
  COV_DIO_FWDALL: cover property (presentDio && ctrl_q[2] ##1 sendLen == 3'h4);

endmodule

`default_nettype wire

// ===== src/iose_flag_if.sv
// interface: carries sampled flags into the byte assembler and the word back
`timescale 1ns/100ps
`default_nettype none

interface iose_flag_if;
  logic [26:0] err;      // sampled error flags, 1 = error
  logic        kindDio;  // module kind
  logic        present;  // module present in slot
  logic [31:0] word;     // assembled state word, byte 0 in low bits

  modport src (output err, output kindDio, output present, input word);
  modport asm (input err, input kindDio, input present, output word);
endinterface

`default_nettype wire

// ===== src/iose_pkg.sv
// package: register map, field positions and reset values of the state word encoder
package iose_pkg;

  // ==========================================================================
  // register map (byte addresses, one aligned word each)
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;  // control: kind, present, forward all
  localparam logic [7:0]  ADDR_STATE  = 8'h04;  // assembled four-byte state word
  localparam logic [7:0]  ADDR_FLAGS  = 8'h08;  // sampled raw error flags

  // ==========================================================================
  // control register fields
  localparam int          CTRL_W          = 3;
  localparam int          CTRL_KIND_BIT   = 0;  // 0 safe i/o, 1 plain digital i/o
  localparam int          CTRL_PRES_BIT   = 1;  // module present in slot
  localparam int          CTRL_FWDALL_BIT = 2;  // plain dio: forward all four bytes
  localparam logic [2:0]  CTRL_RST        = 3'h0;

  // ==========================================================================
  // module kinds
  typedef enum logic [0:0] {
    IOSE_SAFE_IO   = 1'b0,
    IOSE_PLAIN_DIO = 1'b1
  } iose_kind_t;

  // ==========================================================================
  // raw error flag vector layout (1 = error present)
  localparam int          ERR_W        = 27;
  localparam int          ERR_FASTOFF  = 0;
  localparam int          ERR_SUPPLY   = 1;
  localparam int          ERR_CFG      = 2;
  localparam int          ERR_EXT      = 3;
  localparam int          ERR_INT      = 4;
  localparam int          ERR_OUTD     = 5;
  localparam int          ERR_IND      = 6;
  localparam int          ERR_PAIR_LSB = 7;   // four input pairs
  localparam int          ERR_PULS_LSB = 11;  // eight test pulse comparisons
  localparam int          ERR_LOW_LSB  = 19;  // four stuck-at-low
  localparam int          ERR_HIGH_LSB = 23;  // four stuck-at-high
  localparam logic [26:0] FLAGS_RST    = 27'h0000000;

  // ==========================================================================
  // bit positions inside the state bytes
  localparam int          B0_FASTOFF = 6;
  localparam int          B0_SUPPLY  = 5;
  localparam int          B0_CFG     = 4;
  localparam int          B0_EXT     = 2;
  localparam int          B0_INT     = 1;
  localparam int          B1_OUTD    = 7;
  localparam int          B1_IND     = 6;

  // ==========================================================================
  // reset and idle values
  localparam logic [7:0]  BYTE_IDLE  = 8'hFF;         // no error, reserved at one
  localparam logic [31:0] STATE_RST  = 32'hFFFF_FFFF; // empty slot reads all ones
  localparam logic [2:0]  SEND_ONE   = 3'h1;
  localparam logic [2:0]  SEND_ALL   = 3'h4;

endpackage

// ===== src/iose_state_asm.sv
// module: builds the four active-low state bytes from the sampled flags
`timescale 1ns/100ps
`default_nettype none

module iose_state_asm (
  iose_flag_if.asm flg  // flags in, state word out
);

  logic [7:0] b0;
  logic [7:0] b1;
  logic [7:0] b2;
  logic [7:0] b3;

  // ==========================================================================
  // byte assembly: start at all ones, then clear bits whose error is present
  always_comb
  begin
    b0 = iose_pkg::BYTE_IDLE;  // reserved and unused bits stay one
    b1 = iose_pkg::BYTE_IDLE;
    b2 = iose_pkg::BYTE_IDLE;
    b3 = iose_pkg::BYTE_IDLE;
    // common byte 0 and 1 fields, inverted error
    b0[iose_pkg::B0_SUPPLY] = ~flg.err[iose_pkg::ERR_SUPPLY];
    b0[iose_pkg::B0_CFG]    = ~flg.err[iose_pkg::ERR_CFG];
    b0[iose_pkg::B0_EXT]    = ~flg.err[iose_pkg::ERR_EXT];
    b0[iose_pkg::B0_INT]    = ~flg.err[iose_pkg::ERR_INT];
    b1[iose_pkg::B1_OUTD]   = ~flg.err[iose_pkg::ERR_OUTD];
    b1[iose_pkg::B1_IND]    = ~flg.err[iose_pkg::ERR_IND];
    if (flg.kindDio == iose_pkg::IOSE_SAFE_IO)
    begin
      // safe i/o extras
      b0[iose_pkg::B0_FASTOFF] = ~flg.err[iose_pkg::ERR_FASTOFF];
      b1[3:0] = ~flg.err[iose_pkg::ERR_PAIR_LSB +: 4];
      // test pulse results and stuck-at pairs per output
      b2 = ~flg.err[iose_pkg::ERR_PULS_LSB +: 8];
      for (int k = 0; k < 4; k++)
      begin
        b3[2 * k + 1] = ~flg.err[iose_pkg::ERR_LOW_LSB + k];
        b3[2 * k]     = ~flg.err[iose_pkg::ERR_HIGH_LSB + k];
      end
    end
    // plain dio keeps bytes 2 and 3 and byte 1 low bits at one
    // plain dio error bits read zero on error, reserved read one
    if (!flg.present)
    begin
      b0 = iose_pkg::BYTE_IDLE;  // empty slot
      b1 = iose_pkg::BYTE_IDLE;
      b2 = iose_pkg::BYTE_IDLE;
      b3 = iose_pkg::BYTE_IDLE;
    end
    flg.word = {b3, b2, b1, b0};
  end

endmodule

`default_nettype wire

// ===== tb/iose_encoder_tb_top.sv
// testbench: apb and flag stimulus of the state word encoder
`timescale 1ns/100ps
`default_nettype none

module iose_encoder_tb_top;
  logic        clk_sys = 1'b0;
  logic        arst_n  = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [3:0]  pstrb   = 4'hF;
  logic [26:0] errv    = 27'h0000000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] stateWord;
  logic [2:0]  sendLen;
  logic [31:0] fwdWord;
  logic [2:0]  fwdCnt;
  logic [31:0] rd;
  logic        er;
  int          error_cnt   = 0;
  int          comparisons = 0;

  // ==========================================================================
  // clock and units
  always #4 clk_sys = ~clk_sys;

  iose_encoder iose_encoder_i (
    .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fastOffErr(errv[0]), .supplyErr(errv[1]), .cfgInvalid(errv[2]),
    .extErr(errv[3]), .intErr(errv[4]), .outDataErr(errv[5]), .inDataErr(errv[6]),
    .pairErr(errv[10:7]), .pulseErr(errv[18:11]), .stuckLowErr(errv[22:19]),
    .stuckHighErr(errv[26:23]), .stateWord(stateWord), .sendLen(sendLen));

  iose_gateway_model iose_gateway_model_i (
    .clk_sys(clk_sys), .stateWord(stateWord), .sendLen(sendLen), .fwdWord(fwdWord),
    .fwdCnt(fwdCnt));

  // ==========================================================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic conclude();
    if (error_cnt == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // one apb transfer, waits for pready; only the watchdog bounds the wait
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // expected word built from the bit layout of each module kind
  function automatic logic [31:0] expWord(input logic [26:0] e, input logic [2:0] c);
    logic [31:0] w;
    w = 32'hFFFF_FFFF;
    if (c[1])
    begin
      w[6] = ~e[0] | c[0];
      w[5] = ~e[1]; w[4] = ~e[2]; w[2] = ~e[3]; w[1] = ~e[4];
      w[15] = ~e[5]; w[14] = ~e[6];
      if (!c[0])
      begin
        w[11:8] = ~e[10:7];
        w[23:16] = ~e[18:11];
        for (int k = 0; k < 4; k++)
        begin
          w[25 + 2 * k] = ~e[19 + k];
          w[24 + 2 * k] = ~e[23 + k];
        end
      end
    end
    return w;
  endfunction

  task automatic setAll(input logic [2:0] c, input logic [26:0] e);
    apb(1'b1, 8'h00, {29'h0, c});
    errv <= e;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);  // look at outputs once settled, gateway copy included
  endtask

  // ==========================================================================
  // scenarios
  task automatic testEmpty();
    chk(stateWord, 32'hFFFF_FFFF, "reset word");
    setAll(3'h0, 27'h7FFFFFF);
    chk(stateWord, 32'hFFFF_FFFF, "empty slot");
    chk({29'h0, sendLen}, 32'h4, "empty length");
    setAll(3'h5, 27'h7FFFFFF);
    chk(stateWord, 32'hFFFF_FFFF, "empty dio slot");
    chk({29'h0, sendLen}, 32'h4, "empty dio length");
  endtask

  task automatic testWalk();
    logic [2:0] c;
    for (int kd = 0; kd < 2; kd++)
    begin
      c = {1'b0, 1'b1, kd[0]};
      for (int i = 0; i <= 27; i++)
      begin
        setAll(c, (i == 27) ? 27'h7FFFFFF : 27'h1 << i);
        chk(stateWord, expWord(errv, c), "walk word");
      end
    end
    setAll(3'h3, 27'h0);
    chk(stateWord, expWord(27'h0, 3'h3), "dio idle");
  endtask

  task automatic testLen();
    setAll(3'h3, 27'h10);
    chk({29'h0, sendLen}, 32'h1, "dio length");
    chk({29'h0, fwdCnt}, 32'h1, "gateway count");
    chk({24'h0, fwdWord[7:0]}, expWord(27'h10, 3'h3) & 32'h0000_00FF, "gateway byte");
    setAll(3'h7, 27'h10);
    chk({29'h0, sendLen}, 32'h4, "forward all");
    chk(fwdWord, expWord(27'h10, 3'h7), "gateway all bytes");
    setAll(3'h2, 27'h10);
    chk({29'h0, sendLen}, 32'h4, "safe length");
  endtask

  task automatic testApb();
    setAll(3'h2, 27'h0800009);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h2, "ctrl read");
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, expWord(27'h0800009, 3'h2), "state read");
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0800009, "flags read");
    apb(1'b1, 8'h04, 32'h0);
    chk({31'h0, er}, 32'h0, "state write no error");
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, expWord(27'h0800009, 3'h2), "state kept");
    apb(1'b0, 8'h0C, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    pstrb <= 4'h0;
    apb(1'b1, 8'h00, 32'h0);
    pstrb <= 4'hF;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h2, "strobe off");
  endtask

  // ==========================================================================
  // main sequence and watchdog
  initial
  begin
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    testEmpty();
    testWalk();
    testLen();
    testApb();
    conclude();
  end

  initial
  begin
    #400000;
    error_cnt++;
    conclude();
  end
endmodule

`default_nettype wire

// ===== tb/iose_gateway_model.sv
// gateway side model: takes the bytes that the slot hands on each cycle
`timescale 1ns/100ps
`default_nettype none

module iose_gateway_model (
  input  wire logic        clk_sys,   // system clock
  input  wire logic [31:0] stateWord, // slot state word
  input  wire logic [2:0]  sendLen,   // bytes handed on
  output logic      [31:0] fwdWord,   // bytes seen on the network
  output logic      [2:0]  fwdCnt     // count seen on the network
);
  // ==========================================================================
  // capture: bytes not handed on show the inverse, never a stale copy
  always_ff @(posedge clk_sys)
  begin
    fwdCnt  <= sendLen;
    fwdWord <= (sendLen == 3'h1) ? {~stateWord[31:8], stateWord[7:0]} : stateWord;
  end
endmodule

`default_nettype wire
